// ==== psr_cfg.svh ====
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// Command codes seen on the link
`define PSR_CMD_OPERATION 8'h01
`define PSR_CMD_ON_OFF_CFG 8'h02
`define PSR_CMD_CLEAR 8'h03
`define PSR_CMD_SUMMARY 8'h79
`define PSR_CMD_VOUT_STAT 8'h7A
`define PSR_CMD_IOUT_STAT 8'h7B
`define PSR_CMD_INPUT_STAT 8'h7C
`define PSR_CMD_STATUS_TEMP 8'h7D
`define PSR_CMD_STATUS_COMM 8'h7E
`define PSR_CMD_LOG_INDEX 8'hD0
`define PSR_CMD_LOG_STATUS 8'hD1
`define PSR_CMD_LOG_TIME 8'hD2
// Operation control byte
`define PSR_OP_RESET 8'h88
`define PSR_OP_WR_MASK 8'hB0
`define PSR_OP_ON_BIT 7
`define PSR_OP_MARGIN_HI 5
`define PSR_OP_MARGIN_LO 4
`define PSR_MARGIN_BAD 2'h3
// On/off configuration byte
`define PSR_CFG_FIXED 8'h19
`define PSR_CFG_RESET 8'h1D
`define PSR_CFG_OFFSEL_BIT 2
`define PSR_CFG_POL_BIT 1
// Detail status bit positions
`define PSR_VOUT_OV_BIT 7
`define PSR_IOUT_OC_BIT 7
`define PSR_IOUT_WARN_BIT 5
`define PSR_VIN_OV_BIT 7
`define PSR_VIN_UV_BIT 4
`define PSR_VIN_LOWOFF_BIT 3
`define PSR_OT_FAULT_BIT 7
`define PSR_OT_WARN_BIT 6
`define PSR_COMM_CMD_BIT 7
`define PSR_COMM_DATA_BIT 6
`define PSR_COMM_PEC_BIT 5
// Summary word bit positions
`define PSR_W_VOUT 15
`define PSR_W_IOUT 14
`define PSR_W_INPUT 13
`define PSR_W_PG_N 11
`define PSR_W_OFF 6
`define PSR_W_VOUT_OV 5
`define PSR_W_IOUT_OC 4
`define PSR_W_VIN_UV 3
`define PSR_W_TEMP 2
`define PSR_W_COMM 1
// Event log and timing
`define PSR_LOG_DEPTH 20
`define PSR_LOG_IDX_W 5
`define PSR_PIN_COUNT 10
`define PSR_CLK_PERIOD_NS 5
`define PSR_TICK_NS 1000000
`define PSR_TICK_W 18
`endif

// ==== psr_event_log.sv ====
`timescale 1ns/100ps
`include "psr_cfg.svh"
module psr_event_log
   import psr_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   psr_log_if.log lg
);
   logic [15:0] status_mem [0:`PSR_LOG_DEPTH-1];
   logic [15:0] time_mem [0:`PSR_LOG_DEPTH-1];
   logic [`PSR_LOG_IDX_W-1:0] wr_ptr_reg;
   logic [`PSR_LOG_IDX_W-1:0] fill_reg;

   // Physical slot of the idx-th newest entry (0 = newest)
   function automatic logic [`PSR_LOG_IDX_W-1:0] slot_of(
      input logic [`PSR_LOG_IDX_W-1:0] ptr, input logic [`PSR_LOG_IDX_W-1:0] idx);
      logic [`PSR_LOG_IDX_W:0] s;
      s = {1'b0, ptr} + (`PSR_LOG_IDX_W+1)'(`PSR_LOG_DEPTH - 1) - {1'b0, idx};
      if (s >= (`PSR_LOG_IDX_W+1)'(`PSR_LOG_DEPTH)) begin
         s = s - (`PSR_LOG_IDX_W+1)'(`PSR_LOG_DEPTH);
      end
      return s[`PSR_LOG_IDX_W-1:0];
   endfunction

   // entry storage
   // No reset on the arrays, but the fill count resets, so old entries read zero after a logic reset
   always_ff @(posedge core_clk) begin
      if (lg.capture) begin
         status_mem[wr_ptr_reg] <= lg.snap_status;
         time_mem[wr_ptr_reg] <= lg.snap_time;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         fill_reg <= '0;
      end else if (lg.capture) begin
         if (wr_ptr_reg == `PSR_LOG_IDX_W'(`PSR_LOG_DEPTH - 1)) begin
            wr_ptr_reg <= '0;
         end else begin
            wr_ptr_reg <= wr_ptr_reg + `PSR_LOG_IDX_W'(1);
         end
         if (fill_reg != `PSR_LOG_IDX_W'(`PSR_LOG_DEPTH)) begin
            fill_reg <= fill_reg + `PSR_LOG_IDX_W'(1);
         end
      end
   end

   // Registered read port; empty slots read zero
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lg.rd_status <= 16'h0000;
         lg.rd_time <= 16'h0000;
      end else if (lg.rd_index < fill_reg) begin
         lg.rd_status <= status_mem[slot_of(wr_ptr_reg, lg.rd_index)];
         lg.rd_time <= time_mem[slot_of(wr_ptr_reg, lg.rd_index)];
      end else begin
         lg.rd_status <= 16'h0000;
         lg.rd_time <= 16'h0000;
      end
   end

   assign lg.fill = fill_reg;
endmodule

// ==== psr_host_model.sv ====
`timescale 1ns/100ps
module psr_host_model (
   input wire logic link_clk,
   input wire logic link_busy,
   input wire logic [15:0] link_rdata,
   input wire logic link_rvalid,
   output logic [7:0] link_cmd,
   output logic link_wr,
   output logic link_rd,
   output logic [7:0] link_wdata,
   output logic link_pec_fail
);
   int tmo_count = 0;
   // Quiet bus at time zero
   initial begin
      link_cmd = 8'h00;
      link_wr = 1'b0;
      link_rd = 1'b0;
      link_wdata = 8'h00;
      link_pec_fail = 1'b0;
   end
   // One request, strobe held one link cycle, then wait for the answer
   task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [7:0] wd,
      output logic [15:0] rdat);
      int n;
      n = 0;
      @(negedge link_clk);
      link_cmd = cmd;
      link_wdata = wd;
      link_wr = ~rd;
      link_rd = rd;
      @(negedge link_clk);
      link_wr = 1'b0;
      link_rd = 1'b0;
      link_wdata = ~wd; // Released data never shows a stale value
      while ((rd ? !link_rvalid : link_busy) && n < 60) begin
         // Sample mid-cycle, away from the edge that launches the answer
         @(negedge link_clk);
         n++;
      end
      rdat = link_rdata;
      if (n >= 60) tmo_count++;
   endtask
   // Single-cycle packet check failure
   task automatic pec_pulse();
      @(negedge link_clk);
      link_pec_fail = 1'b1;
      @(negedge link_clk);
      link_pec_fail = 1'b0;
   endtask
endmodule

// ==== psr_log_if.sv ====
`timescale 1ns/100ps
`include "psr_cfg.svh"
interface psr_log_if;
   logic capture;
   logic [15:0] snap_status;
   logic [15:0] snap_time;
   logic [`PSR_LOG_IDX_W-1:0] rd_index;
   logic [15:0] rd_status;
   logic [15:0] rd_time;
   logic [`PSR_LOG_IDX_W-1:0] fill;
   modport core (output capture, output snap_status, output snap_time, output rd_index,
      input rd_status, input rd_time, input fill);
   modport log (input capture, input snap_status, input snap_time, input rd_index,
      output rd_status, output rd_time, output fill);
endinterface

// ==== psr_pkg.sv ====
package psr_pkg;
   // Margin selection driven to the power stage
   typedef enum logic [1:0] {
      PSR_MARGIN_OFF = 2'h0,
      PSR_MARGIN_LOW = 2'h1,
      PSR_MARGIN_HIGH = 2'h2
   } psr_margin_t;
   // Core command engine, Gray along idle-exec-answer
   typedef enum logic [1:0] {
      PSR_IDLE = 2'h0,
      PSR_EXEC = 2'h1,
      PSR_ANSWER = 2'h3
   } psr_core_state_t;
endpackage

// ==== psr_regs_props.sv ====
`timescale 1ns/100ps
module psr_regs_props
   import psr_pkg::*;
#(
   parameter bit POL_ACTIVE_HIGH = 1'b0
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic [7:0] link_cmd,
   input wire logic link_wr,
   input wire logic link_rd,
   input wire logic link_busy,
   input wire logic [15:0] link_rdata,
   input wire logic link_rvalid,
   input wire logic output_on,
   input wire psr_margin_t margin_select,
   input wire logic turn_off_select,
   input wire logic onoff_pin_polarity
);
   logic [7:0] cmd_reg;
   logic [7:0] nil_mask;
   logic rv_op;
   logic rv_cfg;
   // Command in flight, kept until its answer
   always_ff @(posedge link_clk) begin
      if ((link_wr | link_rd) & ~link_busy) begin
         cmd_reg <= link_cmd;
      end
   end
   // Detail bits that must never set
   always_comb begin
      case (cmd_reg)
         8'h7A: nil_mask = 8'h7F;
         8'h7B: nil_mask = 8'h5F;
         8'h7C: nil_mask = 8'h67;
         8'h7D: nil_mask = 8'h3F;
         8'h7E: nil_mask = 8'h1F;
         default: nil_mask = 8'h00;
      endcase
   end
   assign rv_op = link_rvalid & (cmd_reg == 8'h01);
   assign rv_cfg = link_rvalid & (cmd_reg == 8'h02);
   a_on_readback: assert property (@(posedge link_clk) disable iff (sys_rst)
      rv_op |-> link_rdata[7] == output_on) else $error("on bit differs from output");
   a_op_fixed: assert property (@(posedge link_clk) disable iff (sys_rst)
      rv_op |-> (link_rdata[7:0] & 8'h4F) == 8'h08) else $error("fixed bits moved");
   a_margin_map: assert property (@(posedge link_clk) disable iff (sys_rst)
      rv_op |-> link_rdata[5:4] == margin_select) else $error("margin output differs");
   a_margin_legal: assert property (@(posedge core_clk) disable iff (sys_rst)
      margin_select != 2'h3) else $error("illegal margin selection");
   a_cfg_fixed: assert property (@(posedge link_clk) disable iff (sys_rst)
      rv_cfg |-> (link_rdata[7:0] & 8'hFB) == {6'h06, POL_ACTIVE_HIGH, 1'b1}
      && link_rdata[2] == turn_off_select) else $error("config byte wrong");
   a_pol_fixed: assert property (@(posedge link_clk) disable iff (sys_rst)
      rv_cfg |-> link_rdata[1] == onoff_pin_polarity) else $error("polarity wrong");
   a_detail_unused: assert property (@(posedge link_clk) disable iff (sys_rst)
      link_rvalid |-> (link_rdata[7:0] & nil_mask) == 8'h00) else $error("unused bit set");
   a_word_unused: assert property (@(posedge link_clk) disable iff (sys_rst)
      link_rvalid && cmd_reg == 8'h79 |-> (link_rdata & 16'h1781) == 16'h0000)
      else $error("unused word bit set");
   a_reset_vals: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> output_on && turn_off_select && margin_select == PSR_MARGIN_OFF)
      else $error("reset values wrong");
   c_op_read: cover property (@(posedge link_clk) rv_op);
   c_cfg_read: cover property (@(posedge link_clk) rv_cfg);
   c_margin_high: cover property (@(posedge core_clk) margin_select == PSR_MARGIN_HIGH);
endmodule

// ==== psr_regs_top.sv ====
`timescale 1ns/100ps
`include "psr_cfg.svh"

// Operation, configuration, status and log rules
// - Operation bit 7 is host writable, switches output at once, resets to one.
// - Operation bits 5:4 writable for margin; bits 3:2 fixed to act-on-fault.
// - Operation bits 6,3,2,1,0 read-only at defaults; writes ignored.
// - Bits 5:2 pattern 00XX off, 0110 margin low, 1010 margin high.
// - Config bit 1 reports pin polarity of the variant, one is active high.
// - Config bit 2 only writable; 7:5 read zero; 4,3,0 read one.
// - Output voltage byte: bit 7 overvoltage fault, others zero, clear at reset.
// - Output current byte: bit 7 fault, bit 5 warning, others zero.
// - Input byte: bit 7 overvoltage, bit 4 undervoltage, bit 3 off for low input.
// - Temperature byte: bit 7 fault, bit 6 warning, others zero.
// - Comm byte: bit 7 bad command, bit 6 bad data, bit 5 check failed.
// - Summary word reports unit off, faults and power-not-good per category.
// - Unsupported status bit positions are never set and read zero.
// - Event log keeps the newest twenty faults with status and time.
module psr_regs_top
   import psr_pkg::*;
#(
   parameter bit POL_ACTIVE_HIGH = 1'b0,
   parameter int unsigned TICK_CYCLES = `PSR_TICK_NS / `PSR_CLK_PERIOD_NS
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic [7:0] link_cmd,
   input wire logic link_wr,
   input wire logic link_rd,
   input wire logic [7:0] link_wdata,
   input wire logic link_pec_fail,
   output logic link_busy,
   output logic [15:0] link_rdata,
   output logic link_rvalid,
   input wire logic flt_vout_ov,
   input wire logic flt_iout_oc,
   input wire logic wrn_iout_oc,
   input wire logic flt_vin_ov,
   input wire logic flt_vin_uv,
   input wire logic vin_low_off,
   input wire logic flt_ot,
   input wire logic wrn_ot,
   input wire logic power_not_good,
   input wire logic hw_off,
   output logic output_on,
   output psr_margin_t margin_select,
   output logic turn_off_select,
   output logic onoff_pin_polarity
);
   // Link domain state
   logic lrst_meta_reg, lrst_reg;
   logic req_tgl_reg, pec_tgl_reg;
   logic [7:0] cmd_l_reg, wdata_l_reg;
   logic isrd_l_reg;
   logic ack_meta_reg, ack_sync_reg, ack_seen_reg;
   logic [15:0] link_rdata_reg;
   logic link_rvalid_reg;
   // Core domain state
   logic req_meta_reg, req_sync_reg, req_seen_reg;
   logic pec_meta_reg, pec_sync_reg, pec_seen_reg;
   logic ack_tgl_reg;
   psr_core_state_t state_reg;
   logic [15:0] core_rdata_reg;
   logic [`PSR_PIN_COUNT-1:0] pin_meta_reg, pin_sync_reg;
   logic [7:0] operation_reg, offsel_reg;
   logic [7:0] vout_status_reg, iout_status_reg, input_status_reg;
   logic [7:0] temp_status_reg, comm_status_reg;
   logic [`PSR_LOG_IDX_W-1:0] log_index_reg;
   logic [`PSR_TICK_W-1:0] tick_div_reg;
   logic [15:0] tick_count_reg;
   logic capture_reg;
   // Combinational
   logic s_vout_ov, s_iout_oc, s_iout_wrn, s_vin_ov, s_vin_uv;
   logic s_low_off, s_ot, s_ot_wrn, s_pg_n, s_hw_off;
   logic accept, pec_evt, bad_cmd, bad_data, ro_cmd, do_clear, op_we, cfg_we, idx_we;
   logic [15:0] rd_next, status_word;
   logic [7:0] cfg_read, vout_set, iout_set, input_set, temp_set, comm_set;
   logic new_fault;
   psr_log_if lg_if();

   // One-hot byte with value v at position pos
   function automatic logic [7:0] bitv(input logic v, input int pos);
      return 8'(v) << pos;
   endfunction

   // Latch with set winning over a clear in the same cycle
   function automatic logic [7:0] latch8(input logic [7:0] cur, input logic [7:0] set,
      input logic clr);
      return (clr ? 8'h00 : cur) | set;
   endfunction

   // Link reset derived from sys_rst; first stage feeds only the second
   always_ff @(posedge link_clk) begin
      lrst_meta_reg <= sys_rst;
      lrst_reg <= lrst_meta_reg;
   end

   // Strobes while a request is in flight are dropped; host watches busy
   assign link_busy = req_tgl_reg != ack_sync_reg;
   assign accept = (link_wr | link_rd) & ~link_busy;

   // Request capture; held stable until the core answers
   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         req_tgl_reg <= 1'b0;
         cmd_l_reg <= 8'h00;
         wdata_l_reg <= 8'h00;
         isrd_l_reg <= 1'b0;
      end else if (accept) begin
         req_tgl_reg <= ~req_tgl_reg;
         cmd_l_reg <= link_cmd;
         wdata_l_reg <= link_wdata;
         isrd_l_reg <= link_rd;
      end
   end

   // check failure reported as a toggle event
   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         pec_tgl_reg <= 1'b0;
      end else if (link_pec_fail) begin
         pec_tgl_reg <= ~pec_tgl_reg;
      end
   end

   // Answer side of the handshake on the link clock
   always_ff @(posedge link_clk) begin
      if (lrst_reg) begin
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
         link_rdata_reg <= 16'h0000;
         link_rvalid_reg <= 1'b0;
      end else begin
         ack_meta_reg <= ack_tgl_reg;
         ack_sync_reg <= ack_meta_reg;
         ack_seen_reg <= ack_sync_reg;
         link_rvalid_reg <= (ack_sync_reg != ack_seen_reg) & isrd_l_reg;
         if ((ack_sync_reg != ack_seen_reg) && isrd_l_reg) begin
            link_rdata_reg <= core_rdata_reg;
         end
      end
   end

   assign link_rdata = link_rdata_reg;
   assign link_rvalid = link_rvalid_reg;

   // Core side synchronisers for the request and check toggles
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
         pec_meta_reg <= 1'b0;
         pec_sync_reg <= 1'b0;
         pec_seen_reg <= 1'b0;
      end else begin
         req_meta_reg <= req_tgl_reg;
         req_sync_reg <= req_meta_reg;
         pec_meta_reg <= pec_tgl_reg;
         pec_sync_reg <= pec_meta_reg;
         pec_seen_reg <= pec_sync_reg;
      end
   end
   assign pec_evt = pec_sync_reg != pec_seen_reg;

   // Fault pins are asynchronous to the core clock
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= {flt_vout_ov, flt_iout_oc, wrn_iout_oc, flt_vin_ov, flt_vin_uv,
            vin_low_off, flt_ot, wrn_ot, power_not_good, hw_off};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   assign {s_vout_ov, s_iout_oc, s_iout_wrn, s_vin_ov, s_vin_uv,
      s_low_off, s_ot, s_ot_wrn, s_pg_n, s_hw_off} = pin_sync_reg;

   // Command engine; crossed words are stable while it runs
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= PSR_IDLE;
         req_seen_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
      end else begin
         case (state_reg)
            PSR_IDLE: begin
               if (req_sync_reg != req_seen_reg) begin
                  req_seen_reg <= req_sync_reg;
                  state_reg <= PSR_EXEC;
               end
            end
            PSR_EXEC: begin
               state_reg <= PSR_ANSWER;
            end
            PSR_ANSWER: begin
               ack_tgl_reg <= ~ack_tgl_reg;
               state_reg <= PSR_IDLE;
            end
            default: begin
               state_reg <= PSR_IDLE;
            end
         endcase
      end
   end

   // polarity from the variant, other fixed bits as built
   assign cfg_read = `PSR_CFG_FIXED | bitv(offsel_reg[`PSR_CFG_OFFSEL_BIT], `PSR_CFG_OFFSEL_BIT)
      | bitv(POL_ACTIVE_HIGH, `PSR_CFG_POL_BIT);

   // Command decode, active only in the execute state
   always_comb begin
      rd_next = 16'h0000;
      ro_cmd = 1'b0;
      bad_cmd = 1'b0;
      bad_data = 1'b0;
      do_clear = 1'b0;
      op_we = 1'b0;
      cfg_we = 1'b0;
      idx_we = 1'b0;
      if (state_reg == PSR_EXEC) begin
         case (cmd_l_reg)
            `PSR_CMD_OPERATION: begin
               rd_next = {8'h00, operation_reg};
               if (wdata_l_reg[`PSR_OP_MARGIN_HI:`PSR_OP_MARGIN_LO] == `PSR_MARGIN_BAD) begin
                  bad_data = ~isrd_l_reg;
               end else begin
                  op_we = ~isrd_l_reg;
               end
            end
            `PSR_CMD_ON_OFF_CFG: begin
               rd_next = {8'h00, cfg_read};
               cfg_we = ~isrd_l_reg;
            end
            `PSR_CMD_CLEAR: begin
               bad_cmd = isrd_l_reg;
               do_clear = ~isrd_l_reg;
            end
            `PSR_CMD_SUMMARY: begin
               rd_next = status_word;
               ro_cmd = 1'b1;
            end
            `PSR_CMD_VOUT_STAT: begin
               rd_next = {8'h00, vout_status_reg};
               ro_cmd = 1'b1;
            end
            `PSR_CMD_IOUT_STAT: begin
               rd_next = {8'h00, iout_status_reg};
               ro_cmd = 1'b1;
            end
            `PSR_CMD_INPUT_STAT: begin
               rd_next = {8'h00, input_status_reg};
               ro_cmd = 1'b1;
            end
            `PSR_CMD_STATUS_TEMP: begin
               rd_next = {8'h00, temp_status_reg};
               ro_cmd = 1'b1;
            end
            `PSR_CMD_STATUS_COMM: begin
               rd_next = {8'h00, comm_status_reg};
               ro_cmd = 1'b1;
            end
            `PSR_CMD_LOG_INDEX: begin
               rd_next = {11'h000, log_index_reg};
               if (wdata_l_reg >= 8'(`PSR_LOG_DEPTH)) begin
                  bad_data = ~isrd_l_reg;
               end else begin
                  idx_we = ~isrd_l_reg;
               end
            end
            `PSR_CMD_LOG_STATUS: begin
               rd_next = lg_if.rd_status;
               ro_cmd = 1'b1;
            end
            `PSR_CMD_LOG_TIME: begin
               rd_next = lg_if.rd_time;
               ro_cmd = 1'b1;
            end
            default: begin
               bad_cmd = 1'b1;
            end
         endcase
         if (ro_cmd && !isrd_l_reg) begin
            bad_cmd = 1'b1;
         end
      end
   end

   // Read answer held for the link side until the next request
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         core_rdata_reg <= 16'h0000;
      end else if (state_reg == PSR_EXEC && isrd_l_reg) begin
         core_rdata_reg <= rd_next;
      end
   end

   // only masked bits take host data
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         operation_reg <= `PSR_OP_RESET;
      end else if (op_we) begin
         operation_reg <= (operation_reg & ~`PSR_OP_WR_MASK) | (wdata_l_reg & `PSR_OP_WR_MASK);
      end
   end

   // turn-off selection, the only writable config bit
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         offsel_reg <= `PSR_CFG_RESET; // Turn-off selection comes up set
         log_index_reg <= '0;
      end else begin
         if (cfg_we) begin
            offsel_reg <= wdata_l_reg;
         end
         if (idx_we) begin
            log_index_reg <= wdata_l_reg[`PSR_LOG_IDX_W-1:0];
         end
      end
   end

   assign vout_set = bitv(s_vout_ov, `PSR_VOUT_OV_BIT);
   assign iout_set = bitv(s_iout_oc, `PSR_IOUT_OC_BIT) | bitv(s_iout_wrn, `PSR_IOUT_WARN_BIT);
   assign input_set = bitv(s_vin_ov, `PSR_VIN_OV_BIT) | bitv(s_vin_uv, `PSR_VIN_UV_BIT)
      | bitv(s_low_off, `PSR_VIN_LOWOFF_BIT);
   assign temp_set = bitv(s_ot, `PSR_OT_FAULT_BIT) | bitv(s_ot_wrn, `PSR_OT_WARN_BIT);
   assign comm_set = bitv(bad_cmd, `PSR_COMM_CMD_BIT) | bitv(bad_data, `PSR_COMM_DATA_BIT)
      | bitv(pec_evt, `PSR_COMM_PEC_BIT);

   // sticky until cleared; unsupported bits never set
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         vout_status_reg <= 8'h00;
         iout_status_reg <= 8'h00;
         input_status_reg <= 8'h00;
         temp_status_reg <= 8'h00;
         comm_status_reg <= 8'h00;
      end else begin
         vout_status_reg <= latch8(vout_status_reg, vout_set, do_clear);
         iout_status_reg <= latch8(iout_status_reg, iout_set, do_clear);
         input_status_reg <= latch8(input_status_reg, input_set, do_clear);
         temp_status_reg <= latch8(temp_status_reg, temp_set, do_clear);
         comm_status_reg <= latch8(comm_status_reg, comm_set, do_clear);
      end
   end

   // summary word from latched detail bytes, operation bit 7 and the live off and power-not-good pins
   assign status_word = {8'(|vout_status_reg) << (`PSR_W_VOUT - 8)
      | 8'(|iout_status_reg) << (`PSR_W_IOUT - 8)
      | 8'(|input_status_reg) << (`PSR_W_INPUT - 8)
      | 8'(s_pg_n) << (`PSR_W_PG_N - 8),
      bitv(~operation_reg[`PSR_OP_ON_BIT] | s_hw_off | s_low_off, `PSR_W_OFF)
      | bitv(vout_status_reg[`PSR_VOUT_OV_BIT], `PSR_W_VOUT_OV)
      | bitv(iout_status_reg[`PSR_IOUT_OC_BIT], `PSR_W_IOUT_OC)
      | bitv(input_status_reg[`PSR_VIN_UV_BIT], `PSR_W_VIN_UV)
      | bitv(|temp_status_reg, `PSR_W_TEMP)
      | bitv(|comm_status_reg, `PSR_W_COMM)};

   // a newly raised fault bit logs one entry
   assign new_fault = |{vout_set & ~vout_status_reg, iout_set & ~iout_status_reg,
      input_set & ~input_status_reg, temp_set & ~temp_status_reg,
      comm_set & ~comm_status_reg};

   // Millisecond time base for log stamps; wraps silently
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tick_div_reg <= '0;
         tick_count_reg <= 16'h0000;
         capture_reg <= 1'b0;
      end else begin
         capture_reg <= new_fault;
         if (tick_div_reg == `PSR_TICK_W'(TICK_CYCLES - 1)) begin
            tick_div_reg <= '0;
            tick_count_reg <= tick_count_reg + 16'h0001;
         end else begin
            tick_div_reg <= tick_div_reg + `PSR_TICK_W'(1);
         end
      end
   end

   // Snapshot taken a cycle late so it includes the new bit
   assign lg_if.capture = capture_reg;
   assign lg_if.snap_status = status_word;
   assign lg_if.snap_time = tick_count_reg;
   assign lg_if.rd_index = log_index_reg;

   psr_event_log u_log (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .lg(lg_if.log)
   );

   assign output_on = operation_reg[`PSR_OP_ON_BIT];
   assign margin_select = psr_margin_t'(operation_reg[`PSR_OP_MARGIN_HI:`PSR_OP_MARGIN_LO]);
   assign turn_off_select = offsel_reg[`PSR_CFG_OFFSEL_BIT];
   assign onoff_pin_polarity = POL_ACTIVE_HIGH;
endmodule

// ==== psr_regs_top_tb_top.sv ====
`timescale 1ns/100ps
module psr_regs_top_tb_top
   import psr_pkg::*;
;
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [9:0] flt = 10'h000;
   logic [7:0] link_cmd, link_wdata;
   logic link_wr, link_rd, link_pec_fail, link_busy, link_rvalid;
   logic output_on, turn_off_select, onoff_pin_polarity;
   logic [15:0] link_rdata, rd;
   psr_margin_t margin_select;
   int err_count = 0;
   int cmp_count = 0;
   // Core and link clocks, unrelated in phase
   initial forever #2.5 core_clk = ~core_clk;
   initial begin
      #3.7;
      forever #7.5 link_clk = ~link_clk;
   end
   psr_regs_top #(.TICK_CYCLES(10)) DUT (.core_clk, .sys_rst, .link_clk, .link_cmd,
      .link_wr, .link_rd, .link_wdata, .link_pec_fail, .link_busy, .link_rdata,
      .link_rvalid, .flt_vout_ov(flt[0]), .flt_iout_oc(flt[1]), .wrn_iout_oc(flt[2]),
      .flt_vin_ov(flt[3]), .flt_vin_uv(flt[4]), .vin_low_off(flt[5]), .flt_ot(flt[6]),
      .wrn_ot(flt[7]), .power_not_good(flt[8]), .hw_off(flt[9]), .output_on,
      .margin_select, .turn_off_select, .onoff_pin_polarity);
   psr_host_model HOST (.link_clk, .link_busy, .link_rdata, .link_rvalid, .link_cmd,
      .link_wr, .link_rd, .link_wdata, .link_pec_fail);
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      err_count += HOST.tmo_count;
      $display("Compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic op(input logic r, input logic [7:0] c, input logic [7:0] d);
      HOST.xfer(r, c, d, rd);
      if (HOST.tmo_count > 0) final_report();
   endtask
   task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
      op(1'b1, c, 8'h00);
      check(rd, exp);
   endtask
   initial begin
      repeat (20) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (6) @(negedge link_clk);
      // Reset values and clear status
      check({15'h0000, output_on}, 16'h0001);
      rdchk(8'h01, 16'h0088);
      rdchk(8'h02, 16'h001D);
      check({15'h0000, turn_off_select}, 16'h0001);
      check({15'h0000, onoff_pin_polarity}, 16'h0000);
      rdchk(8'h79, 16'h0000);
      rdchk(8'h7A, 16'h0000);
      rdchk(8'h7B, 16'h0000);
      rdchk(8'h7D, 16'h0000);
      // Margin low with output off, then margin high with output on
      op(1'b0, 8'h01, 8'h5F);
      rdchk(8'h01, 16'h0018);
      check({14'h0000, margin_select}, 16'h0001);
      check({15'h0000, output_on}, 16'h0000);
      op(1'b0, 8'h01, 8'hA0);
      rdchk(8'h01, 16'h00A8);
      check({14'h0000, margin_select}, 16'h0002);
      // Refused margin, unknown code and failed packet check
      op(1'b0, 8'h01, 8'hB0);
      op(1'b0, 8'h55, 8'h00);
      HOST.pec_pulse();
      rdchk(8'h01, 16'h00A8);
      rdchk(8'h7E, 16'h00E0);
      rdchk(8'h79, 16'h0002);
      op(1'b0, 8'h03, 8'h00);
      rdchk(8'h7E, 16'h0000);
      // Write to a read-only code counts as a bad command
      op(1'b0, 8'h79, 8'h00);
      rdchk(8'h7E, 16'h0080);
      op(1'b0, 8'h03, 8'h00);
      // Only the turn-off selection is writable
      op(1'b0, 8'h02, 8'hE2);
      rdchk(8'h02, 16'h0019);
      check({15'h0000, turn_off_select}, 16'h0000);
      op(1'b0, 8'h02, 8'h04);
      rdchk(8'h02, 16'h001D);
      // Fault pins pulse; detail bits stay latched after they drop
      @(negedge core_clk);
      flt = 10'h0FF;
      repeat (8) @(negedge core_clk);
      flt = 10'h000;
      rdchk(8'h7A, 16'h0080);
      rdchk(8'h7B, 16'h00A0);
      rdchk(8'h7C, 16'h0098);
      rdchk(8'h7D, 16'h00C0);
      rdchk(8'h79, 16'hE03C);
      @(negedge core_clk);
      flt = 10'h300;
      rdchk(8'h79, 16'hE87C);
      @(negedge core_clk);
      flt = 10'h000;
      // Newest log entry, then an index equal to the depth
      op(1'b0, 8'hD0, 8'h00);
      rdchk(8'hD1, 16'hE07C);
      op(1'b0, 8'hD0, 8'h14);
      rdchk(8'h7E, 16'h0040);
      final_report();
   end
endmodule
bind psr_regs_top psr_regs_props #(.POL_ACTIVE_HIGH(POL_ACTIVE_HIGH)) u_props (.core_clk,
   .sys_rst, .link_clk, .link_cmd, .link_wr, .link_rd, .link_busy, .link_rdata,
   .link_rvalid, .output_on, .margin_select, .turn_off_select, .onoff_pin_polarity);
